// ---- rlts_supervisor.v ----
`timescale 1ns/1ps
`include "rlts_defs.vh"
module rlts_supervisor #(
  parameter CYCLE_CLKS = `RLTS_CYCLE_CLKS,
  parameter W = `RLTS_MSG_W
) (
  input wire ref_clk,
  input wire rst,
  input wire [W-1:0] local_tx_data,
  input wire local_tx_valid,
  output wire [W-1:0] local_rx_data,
  output wire local_rx_valid,
  input wire local_rx_ready,
  output reg [W-1:0] radio_tx_data,
  output reg radio_tx_strobe,
  input wire ack_in,
  input wire nack_in,
  input wire channel_blocked,
  input wire [W-1:0] radio_rx_data,
  input wire radio_rx_good,
  input wire radio_rx_lost,
  input wire [7:0] up_thresh,
  input wire [7:0] down_thresh,
  input wire sub_link,
  input wire sub_device,
  output reg link_up,
  output reg link_status_valid,
  output reg device_alive,
  output reg tx_drop,
  output reg tx_overflow,
  output wire rx_overflow
);
  // slot timing, sequencer and link state
  reg [31:0] slot_cnt;
  reg slot_tick;
  reg [1:0] state;
  reg [1:0] retry;
  reg [7:0] good_run;
  reg [7:0] lost_run;
  reg [7:0] alive_cnt;
  reg link_int;
  reg head_gone;
  wire [W-1:0] txq_data;
  wire txq_valid;
  reg txq_take;
  wire txq_drop;
  wire head_lost = head_gone | txq_drop; // head already pushed out by overflow
  // zero thresholds act as one
  wire [7:0] up_eff = (up_thresh == 8'h00) ? 8'h01 : up_thresh;
  wire [7:0] dn_eff = (down_thresh == 8'h00) ? 8'h01 : down_thresh;

  // transmit queue
  rlts_queue #(.W(W), .AW(`RLTS_TXQ_AW)) u_txq (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(local_tx_data),
    .in_valid(local_tx_valid),
    .out_data(txq_data),
    .out_valid(txq_valid),
    .out_take(txq_take),
    .drop(txq_drop)
  );

  // receive buffer toward the local bus
  rlts_queue #(.W(W), .AW(`RLTS_RXQ_AW)) u_rxq (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(radio_rx_data),
    .in_valid(radio_rx_good),
    .out_data(local_rx_data),
    .out_valid(local_rx_valid),
    .out_take(local_rx_ready),
    .drop(rx_overflow)
  );

  // transmission slot timer
  always @(posedge ref_clk) begin
    if (rst) begin
      slot_cnt <= 32'h00000000;
      slot_tick <= 1'b0;
    end else if (slot_cnt == CYCLE_CLKS - 1) begin
      slot_cnt <= 32'h00000000;
      slot_tick <= 1'b1;
    end else begin
      slot_cnt <= slot_cnt + 32'h00000001;
      slot_tick <= 1'b0;
    end
  end

  // transmit sequencer: head of queue stays until acked or out of retries
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= `RLTS_ST_IDLE;
      retry <= 2'h0;
      radio_tx_data <= {W{1'b0}};
      radio_tx_strobe <= 1'b0;
      txq_take <= 1'b0;
      tx_drop <= 1'b0;
    end else begin
      radio_tx_strobe <= 1'b0;
      txq_take <= 1'b0;
      tx_drop <= 1'b0;
      case (state)
        `RLTS_ST_IDLE: begin
          if (slot_tick && txq_valid && !txq_take && !channel_blocked) begin
            radio_tx_data <= txq_data;
            radio_tx_strobe <= 1'b1;
            retry <= 2'h0;
            state <= `RLTS_ST_WAIT;
          end
        end
        `RLTS_ST_SEND: begin
          if (slot_tick && !channel_blocked) begin
            radio_tx_strobe <= 1'b1;
            state <= `RLTS_ST_WAIT;
          end
        end
        `RLTS_ST_WAIT: begin
          if (ack_in) begin
            txq_take <= !head_lost;
            state <= `RLTS_ST_IDLE;
          end else if (nack_in || slot_tick) begin
            if (retry == `RLTS_MAX_RETRY) begin
              txq_take <= !head_lost;
              tx_drop <= 1'b1;
              state <= `RLTS_ST_IDLE;
            end else begin
              retry <= retry + 2'h1;
              if (slot_tick && !channel_blocked) begin
                radio_tx_strobe <= 1'b1;
              end else begin
                state <= `RLTS_ST_SEND;
              end
            end
          end
        end
        default: begin
          state <= `RLTS_ST_IDLE;
        end
      endcase
    end
  end

  // overflow may discard the message in flight; its completion pops no second one unless the overflow push lands on the same edge as the completion
  always @(posedge ref_clk) begin
    if (rst) begin
      head_gone <= 1'b0;
    end else if (state == `RLTS_ST_IDLE) begin
      head_gone <= 1'b0;
    end else if (txq_drop) begin
      head_gone <= 1'b1;
    end
  end

  // link supervision from consecutive good and lost runs
  always @(posedge ref_clk) begin
    if (rst) begin
      good_run <= 8'h00;
      lost_run <= 8'h00;
      link_int <= 1'b0;
    end else if (radio_rx_good) begin
      lost_run <= 8'h00;
      if (good_run != 8'hff) begin
        good_run <= good_run + 8'h01;
      end
      if (good_run + 8'h01 >= up_eff) begin
        link_int <= 1'b1;
      end
    end else if (radio_rx_lost) begin
      good_run <= 8'h00;
      if (lost_run != 8'hff) begin
        lost_run <= lost_run + 8'h01;
      end
      if (lost_run + 8'h01 >= dn_eff) begin
        link_int <= 1'b0;
      end
    end
  end

  // alive counter in slots
  always @(posedge ref_clk) begin
    if (rst) begin
      alive_cnt <= 8'h00;
    end else if (slot_tick) begin
      alive_cnt <= (alive_cnt == `RLTS_ALIVE_CYCLES - 8'h01) ? 8'h00 : alive_cnt + 8'h01;
    end
  end

  // status outputs gated by subscription, except tx_overflow
  always @(posedge ref_clk) begin
    if (rst) begin
      link_up <= 1'b0;
      link_status_valid <= 1'b0;
      device_alive <= 1'b0;
      tx_overflow <= 1'b0;
    end else begin
      link_up <= sub_link & link_int;
      link_status_valid <= sub_link;
      device_alive <= sub_device & slot_tick & (alive_cnt == 8'h00);
      tx_overflow <= txq_drop;
    end
  end
endmodule

// ---- rlts_defs.vh ----
`ifndef RLTS_DEFS_VH
`define RLTS_DEFS_VH
// transmission cycle figures
`define RLTS_CYCLE_NS 4800000
`define RLTS_CLK_NS 50
`define RLTS_CYCLE_CLKS (`RLTS_CYCLE_NS / `RLTS_CLK_NS)
// retry cap
`define RLTS_MAX_RETRY 2'h2
// alive indication period in transmission cycles
`define RLTS_ALIVE_CYCLES 8'h0a
// fifo sizing
`define RLTS_MSG_W 32
`define RLTS_TXQ_AW 4
`define RLTS_RXQ_AW 4
// tx states
`define RLTS_ST_IDLE 2'h0
`define RLTS_ST_SEND 2'h1
`define RLTS_ST_WAIT 2'h2
`endif

// ---- rlts_queue.v ----
`timescale 1ns/1ps
`include "rlts_defs.vh"
// oldest-first message queue; a push into a full queue drops the oldest entry
module rlts_queue #(
  parameter W = `RLTS_MSG_W,
  parameter AW = `RLTS_TXQ_AW
) (
  input wire ref_clk,
  input wire rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_take,
  output reg drop
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire [AW:0] count = wr_ptr - rd_ptr;
  wire full = (count == DEPTH);
  wire take = out_take && out_valid;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr[AW-1:0]];
  // storage write
  always @(posedge ref_clk) begin
    if (in_valid) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  // pointers; overflow advances the read pointer, discarding the oldest
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      drop <= 1'b0;
    end else begin
      drop <= in_valid && full && !take;
      if (in_valid) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (take || (in_valid && full)) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ---- rlts_peer.sv ----
`timescale 1ns/1ps
// far side bridge: answers each packet five cycles after it arrives
module rlts_peer (
  input wire logic ref_clk,
  input wire logic radio_tx_strobe,
  input wire logic ack_en,
  output logic ack_in = 1'b0,
  output logic nack_in = 1'b0
);
  logic [3:0] dly = 4'h0;
  // delay line turns a received packet into an ack, or a nack when acks are off
  always @(posedge ref_clk) begin
    dly <= {dly[2:0], radio_tx_strobe};
    ack_in <= dly[3] & ack_en;
    nack_in <= dly[3] & ~ack_en;
  end
endmodule

// ---- rlts_supervisor_monitor.sv ----
`timescale 1ns/1ps
module rlts_mon (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] radio_tx_data,
  input wire logic radio_tx_strobe,
  input wire logic channel_blocked,
  input wire logic radio_rx_good,
  input wire logic local_rx_valid,
  input wire logic sub_link,
  input wire logic sub_device,
  input wire logic link_up,
  input wire logic link_status_valid,
  input wire logic device_alive,
  input wire logic tx_drop
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // packets and alive pulses keep their spacing, status follows subscriptions
  chk_slot_spacing: assert property (radio_tx_strobe |=> !radio_tx_strobe [*8])
    else $error("strobes closer than a slot");
  chk_no_blocked_send: assert property (radio_tx_strobe |-> !$past(channel_blocked))
    else $error("sent while channel blocked");
  chk_data_holds: assert property (!radio_tx_strobe |-> $stable(radio_tx_data))
    else $error("tx data moved without a send");
  chk_link_unsub: assert property (!sub_link && !$past(sub_link) |-> !link_up)
    else $error("link state shown unsubscribed");
  chk_valid_follows: assert property (!$past(rst) |-> link_status_valid == $past(sub_link))
    else $error("status valid not following subscription");
  chk_alive_sub: assert property (device_alive |-> $past(sub_device))
    else $error("alive pulse unsubscribed");
  chk_alive_period: assert property (device_alive |=> !device_alive [*8])
    else $error("alive pulses too close");
  chk_rx_buffered: assert property (radio_rx_good |-> ##[1:2] local_rx_valid)
    else $error("good packet not buffered");
  cov_send: cover property (radio_tx_strobe);
  cov_drop: cover property (tx_drop);
  cov_link: cover property ($rose(link_up));
  cov_alive: cover property (device_alive);
endmodule
bind rlts_supervisor rlts_mon u_mon (.*);

// ---- rlts_supervisor_tb_top.sv ----
`timescale 1ns/1ps
module rlts_supervisor_tb_top;
  logic ref_clk = 0, rst = 1, tx_v = 0, ack_en = 1, rx_g = 0, rx_l = 0, rdy = 0;
  logic blk = 0, sub = 1;
  logic [31:0] tx_d = 0, rx_d = 0;
  wire [31:0] lrx_d, rtx_d;
  wire lrx_v, stb, ack, nack, lup, lsv, alive, drop, tov, rov;
  int mismatches = 0, n_checks = 0;
  rlts_supervisor #(.CYCLE_CLKS(20)) uut (.ref_clk(ref_clk), .rst(rst), .local_tx_data(tx_d),
    .local_tx_valid(tx_v), .local_rx_data(lrx_d), .local_rx_valid(lrx_v), .local_rx_ready(rdy),
    .radio_tx_data(rtx_d), .radio_tx_strobe(stb), .ack_in(ack), .nack_in(nack),
    .channel_blocked(blk), .radio_rx_data(rx_d), .radio_rx_good(rx_g), .radio_rx_lost(rx_l),
    .up_thresh(8'h03), .down_thresh(8'h02), .sub_link(sub), .sub_device(1'b1),
    .link_up(lup), .link_status_valid(lsv), .device_alive(alive), .tx_drop(drop),
    .tx_overflow(tov), .rx_overflow(rov));
  rlts_peer peer (.ref_clk(ref_clk), .radio_tx_strobe(stb), .ack_en(ack_en), .ack_in(ack),
    .nack_in(nack));
  // 20 MHz clock
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_stb(logic [31:0] exp);
    int i;
    for (i = 0; i < 100 && !stb; i++) @(negedge ref_clk);
    if (i == 100) begin
      mismatches++;
      print_verdict;
    end else begin
      chk(rtx_d, exp);
      @(negedge ref_clk);
    end
  endtask
  task automatic push(logic [31:0] d);
    tx_d = d;
    tx_v = 1;
    @(negedge ref_clk);
  endtask
  // two queued messages go out in order on slot ticks
  task automatic t_order;
    push(32'h0000_00a1);
    push(32'h0000_00b2);
    tx_v = 0;
    wait_stb(32'h0000_00a1);
    wait_stb(32'h0000_00b2);
  endtask
  // unacked message is sent three times, dropped, then the next one goes
  task automatic t_retry;
    int i, n, f, l;
    repeat (10) @(negedge ref_clk);
    ack_en = 0;
    push(32'h0000_00c3);
    tx_v = 0;
    n = 0;
    f = 0;
    l = 0;
    for (i = 0; i < 200 && !drop; i++) begin
      @(negedge ref_clk);
      if (stb && n == 0) f = i;
      if (stb) l = i;
      n += stb;
    end
    if (i == 200) begin
      mismatches++;
      print_verdict;
    end else begin
      chk(n, 3);
      chk(l - f, 40);
      chk(rtx_d, 32'h0000_00c3);
      ack_en = 1;
      push(32'h0000_00d4);
      tx_v = 0;
      wait_stb(32'h0000_00d4);
    end
  endtask
  // link goes up after three good packets and down after two lost
  task automatic t_link;
    int i;
    rx_d = 32'h0000_0d4e;
    for (i = 0; i < 3; i++) begin
      chk(lup, 1'b0);
      rx_g = 1;
      @(negedge ref_clk);
      rx_g = 0;
      @(negedge ref_clk);
    end
    repeat (2) @(negedge ref_clk);
    chk(lup, 1'b1);
    chk(lsv, 1'b1);
    chk(lrx_d, 32'h0000_0d4e);
    rdy = 1;
    repeat (3) @(negedge ref_clk);
    rdy = 0;
    chk(lrx_v, 1'b0);
    for (i = 0; i < 2; i++) begin
      chk(lup, 1'b1);
      rx_l = 1;
      @(negedge ref_clk);
      rx_l = 0;
      @(negedge ref_clk);
    end
    repeat (2) @(negedge ref_clk);
    chk(lup, 1'b0);
  endtask
  // receive overflow drops the oldest, status follows subscription, alive pulses
  task automatic t_status;
    int i;
    for (i = 0; i < 17; i++) begin
      rx_d = 32'h0000_0200 + i;
      rx_g = 1;
      @(negedge ref_clk);
    end
    rx_g = 0;
    chk(rov, 1'b1);
    chk(lrx_d, 32'h0000_0201);
    rdy = 1;
    repeat (16) @(negedge ref_clk);
    rdy = 0;
    chk(lrx_v, 1'b0);
    chk(lup, 1'b1);
    sub = 0;
    repeat (2) @(negedge ref_clk);
    chk(lup, 1'b0);
    chk(lsv, 1'b0);
    sub = 1;
    repeat (2) @(negedge ref_clk);
    chk(lup, 1'b1);
    for (i = 0; i < 250 && !alive; i++) @(negedge ref_clk);
    chk(alive, 1'b1);
    @(negedge ref_clk);
    chk(alive, 1'b0);
  endtask
  // blocked slots keep the queue; overflow drops the oldest, then order resumes
  task automatic t_block;
    int i, n;
    blk = 1;
    for (i = 0; i < 17; i++) push(32'h0000_0100 + i);
    tx_v = 0;
    @(negedge ref_clk);
    chk(tov, 1'b1);
    n = 0;
    for (i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      n += stb;
    end
    chk(n, 0);
    blk = 0;
    wait_stb(32'h0000_0101);
    wait_stb(32'h0000_0102);
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 0;
    t_order;
    t_retry;
    t_link;
    t_status;
    t_block;
    repeat (200) @(negedge ref_clk);
    print_verdict;
  end
endmodule
